// ### ampctl_pkg.sv
// Shared constants and types of the amplifier control port.
package ampctl_pkg;
  localparam logic [6:0] AMPC_BASE_ADDR = 7'h6A;
  localparam int AMPC_NUM_REGS = 41;
  localparam logic [7:0] AMPC_REG_CH_CTRL = 8'h04;
  localparam logic [7:0] AMPC_REG_CH_STATE = 8'h0F;
  localparam logic [7:0] AMPC_REG_CH_FAULT = 8'h10;
  localparam logic [7:0] AMPC_REG_GLB_FAULT = 8'h11;
  localparam logic [7:0] AMPC_REG_WARN = 8'h13;
  localparam logic [7:0] AMPC_REG_PIN_CTRL = 8'h14;
  localparam logic [7:0] AMPC_REG_MISC3 = 8'h21;
  localparam int AMPC_CLEAR_BIT = 7;
  localparam logic [7:0] AMPC_CH_CTRL_RST = 8'h00;
  localparam logic [7:0] AMPC_PIN_CTRL_RST = 8'h00;
  // Pin control mask bits (set = keep that category off the pin).
  localparam int AMPC_MSK_CLIP = 0;
  localparam int AMPC_MSK_HOTWARN = 1;
  localparam int AMPC_MSK_VOLT = 2;
  localparam int AMPC_MSK_HOTOFF = 3;
  localparam int AMPC_MSK_CHAN = 4;
  localparam int AMPC_MSK_ILIM = 5;
  localparam int AMPC_MSK_POR = 6;
  // Warning register layout.
  localparam int AMPC_W_POR = 0;
  localparam int AMPC_W_HOTWARN = 1;
  localparam int AMPC_W_CLIP = 2;
  localparam int AMPC_W_ILIM = 3;
  // Global fault register layout.
  localparam int AMPC_G_LOW = 0;
  localparam int AMPC_G_HIGH = 1;
  localparam int AMPC_G_HOTOFF = 2;
  // Requested and effective channel state, two bits per channel.
  typedef enum logic [1:0] {
    AMPC_ST_PLAY = 2'h0,
    AMPC_ST_HIZ = 2'h1,
    AMPC_ST_MUTE = 2'h2,
    AMPC_ST_STANDBY = 2'h3
  } ampc_chst_t;
  localparam logic [1:0] AMPC_ST_STANDBY_CODE = 2'h3;
  localparam logic [1:0] AMPC_ST_HIZ_CODE = 2'h1;
  localparam logic [1:0] AMPC_ST_PLAY_CODE = 2'h0;
  localparam logic [1:0] AMPC_ST_MUTE_CODE = 2'h2;
endpackage : ampctl_pkg

// ### ampc_bit_sampler.sv
// Link-side bit sampler clocked by the bus clock.
`timescale 1ns/1ps
module ampc_bit_sampler (
  input wire logic scl_clk, // bus clock from the master
  input wire logic reset_n, // active-low reset
  input wire logic sda_in, // bus data level
  output logic bit_val, // last sampled data bit
  output logic bit_tgl // flips once per sampled bit
);
  typedef struct packed {
    logic bit_val;
    logic tgl;
  } ampc_smp_t;
  ampc_smp_t q_reg;
  ampc_smp_t q_next;

  // Data is held until the next rising edge, which is microseconds away,
  // so the toggle alone needs synchronising on the system side.
  always_comb begin
    q_next = q_reg;
    q_next.bit_val = sda_in;
    q_next.tgl = ~q_reg.tgl;
  end

  // The bus clock may stand still, so reset acts without it.
  always_ff @(posedge scl_clk or negedge reset_n) begin
    if (!reset_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign bit_val = q_reg.bit_val;
  assign bit_tgl = q_reg.tgl;
endmodule : ampc_bit_sampler

// ### ampc_fault_ctrl.sv
// Operating states, fault and warning reporting of the amplifier.
`timescale 1ns/1ps
module ampc_fault_ctrl
  import ampctl_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // synchronous active-low reset
  input wire logic ce, // clock enable
  input wire logic [7:0] ch_ctrl, // requested states, two bits a channel
  input wire logic [7:0] pin_mask, // pin mask bits
  input wire logic fault_clear, // one-cycle clear of sticky bits
  input wire logic supply_low_event, // rail undervoltage, async
  input wire logic supply_high_event, // rail overvoltage, async
  input wire logic overheat_caution, // thermal warning, async
  input wire logic overheat_shutdown, // thermal shutdown, async
  input wire logic clip_event, // any channel clipping, async
  input wire logic ilimit_event, // current limiting active, async
  input wire logic [NUM_CH-1:0] chan_oc, // channel overcurrent, async
  input wire logic [NUM_CH-1:0] chan_dc, // channel DC detect, async
  output logic [7:0] st_report, // effective state of each channel
  output logic [7:0] ch_fault_rep, // latched channel faults
  output logic [7:0] glb_fault_rep, // live global faults
  output logic [7:0] warn_rep, // sticky warnings
  output logic osc_run, // oscillator running
  output logic [NUM_CH-1:0] cur_limit, // current limit engaged
  output logic warn_pin_o, // warning pin output level
  output logic warn_pin_oe, // warning pin driven low
  output logic fault_pin_o, // error pin output level
  output logic fault_pin_oe // error pin driven low
);
  localparam int NIN = 6 + 2 * NUM_CH;
  initial begin
    if (NUM_CH != 4) $error("ampc_fault_ctrl serves four channels only");
  end

  typedef struct packed {
    logic [NIN-1:0] s1;
    logic [NIN-1:0] s2;
    logic [3:0] warn;
    logic [NUM_CH-1:0] oc_lat;
    logic [NUM_CH-1:0] dc_lat;
    logic [7:0] st;
    logic [NUM_CH-1:0] lim;
    logic warn_drv;
    logic fault_drv;
  } ampc_flt_t;
  ampc_flt_t q_reg;
  ampc_flt_t q_next;

  logic low_s, high_s, hotw_s, hots_s, clip_s, ilim_s;
  logic [NUM_CH-1:0] oc_s, dc_s;
  assign {low_s, high_s, hotw_s, hots_s, clip_s, ilim_s, oc_s, dc_s} = q_reg.s2;

  always_comb begin
    logic any_active;
    logic any_run;
    logic glb_hiz;
    logic [1:0] req;
    any_active = 1'b0;
    any_run = 1'b0;
    glb_hiz = low_s | high_s | hots_s;
    req = 2'h0;
    q_next = q_reg;
    q_next.s1 = {supply_low_event, supply_high_event, overheat_caution,
                 overheat_shutdown, clip_event, ilimit_event, chan_oc, chan_dc};
    q_next.s2 = q_reg.s1;
    for (int i = 0; i < NUM_CH; i++) begin
      req = ch_ctrl[2*i +: 2];
      if (req == AMPC_ST_MUTE_CODE || req == AMPC_ST_PLAY_CODE) begin
        any_active = 1'b1;
      end
    end
    // Clear first so that an event in the same cycle still sets its bit.
    if (fault_clear) begin
      q_next.warn = '0;
      q_next.oc_lat = '0;
      q_next.dc_lat = '0;
    end
    if (hotw_s && !(&ch_ctrl)) q_next.warn[AMPC_W_HOTWARN] = 1'b1;
    if (any_active && clip_s) q_next.warn[AMPC_W_CLIP] = 1'b1;
    if (any_active && ilim_s) q_next.warn[AMPC_W_ILIM] = 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      req = ch_ctrl[2*i +: 2];
      q_next.lim[i] = 1'b0;
      if (req == AMPC_ST_MUTE_CODE || req == AMPC_ST_PLAY_CODE) begin
        if (oc_s[i]) q_next.oc_lat[i] = 1'b1;
        if (dc_s[i]) q_next.dc_lat[i] = 1'b1;
        q_next.lim[i] = ilim_s;
      end
      // Standby wins, then any protective Hi-Z, then the request.
      if (req == AMPC_ST_STANDBY_CODE) begin
        q_next.st[2*i +: 2] = AMPC_ST_STANDBY_CODE;
      end else if (glb_hiz || q_next.oc_lat[i] || q_next.dc_lat[i]) begin
        q_next.st[2*i +: 2] = AMPC_ST_HIZ_CODE;
      end else begin
        q_next.st[2*i +: 2] = req;
      end
    end
    // Masks act only on the pins, never on reports or actions.
    q_next.warn_drv = (q_next.warn[AMPC_W_POR] & ~pin_mask[AMPC_MSK_POR])
      | (q_next.warn[AMPC_W_HOTWARN] & ~pin_mask[AMPC_MSK_HOTWARN])
      | (q_next.warn[AMPC_W_CLIP] & ~pin_mask[AMPC_MSK_CLIP])
      | (q_next.warn[AMPC_W_ILIM] & ~pin_mask[AMPC_MSK_ILIM]);
    q_next.fault_drv = ((low_s | high_s) & ~pin_mask[AMPC_MSK_VOLT])
      | (hots_s & ~pin_mask[AMPC_MSK_HOTOFF])
      | ((|(q_next.oc_lat | q_next.dc_lat)) & ~pin_mask[AMPC_MSK_CHAN]);
    // Follows the registered state so the oscillator and report agree.
    for (int i = 0; i < NUM_CH; i++) begin
      if (q_reg.st[2*i +: 2] != AMPC_ST_STANDBY_CODE) any_run = 1'b1;
    end
    osc_run = any_run;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q_reg <= '0;
      q_reg.warn[AMPC_W_POR] <= 1'b1;
      q_reg.warn_drv <= 1'b1;
      q_reg.st <= 8'hFF;
    end else if (ce) begin
      q_reg <= q_next;
    end
  end

  assign st_report = q_reg.st;
  assign ch_fault_rep = {q_reg.oc_lat, q_reg.dc_lat};
  assign glb_fault_rep = {5'h00, hots_s, high_s, low_s};
  assign warn_rep = {4'h0, q_reg.warn};
  assign cur_limit = q_reg.lim;
  assign warn_pin_o = 1'b0;
  assign warn_pin_oe = q_reg.warn_drv;
  assign fault_pin_o = 1'b0;
  assign fault_pin_oe = q_reg.fault_drv;
endmodule : ampc_fault_ctrl

// ### ampc_ctrl_port.sv
// Two-wire target control port with register storage and fault tables.
`timescale 1ns/1ps
// Overview of operation
// - Bus address comes from two select pins; 0xD4 base, read adds one.
// - Works at 100 and 400 kbps for single and sequential transfers.
// - Target only: never starts transfers, never stretches the clock.
// - Every byte moves most significant bit first.
// - The receiver of each byte acknowledges in the next clock period.
// - SDA falling with SCL high starts; SDA rising with SCL high stops.
// - Data bits change SDA only while SCL is low.
// - Acknowledge holds SDA low for the whole acknowledge clock period.
// - Any number of bytes may pass between start and stop.
// - Single write: address, register pointer, data, each acknowledged.
// - Each written byte is acknowledged and the pointer then advances.
// - Single read: set pointer, repeated start, read address, one byte.
// - Sequential read returns successive registers until master NACKs.
// - Standby, Hi-Z, mute and play states; port active in all.
// - Reset warns and holds standby while asserted, then channels play; supply and thermal faults force Hi-Z.
// - Clip and limiting warn; channel faults report and force Hi-Z.
// - Warning pin is active low and latched until the clear bit.
// - Error pin follows live global and latched channel errors; masks only affect the pin.
module ampc_ctrl_port
  import ampctl_pkg::*;
#(
  parameter int NUM_REGS = AMPC_NUM_REGS
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic reset_n, // synchronous active-low reset
  input wire logic ce, // clock enable, freezes state when low
  input wire logic scl_clk, // bus clock from the master
  input wire logic scl_in, // bus clock level
  input wire logic sda_in, // bus data level
  output logic sda_o, // bus data output level
  output logic sda_oe, // high while pulling SDA low
  input wire logic addr_select_low, // address select pin 0
  input wire logic addr_select_high, // address select pin 1
  input wire logic supply_low_event, // rail undervoltage
  input wire logic supply_high_event, // rail overvoltage
  input wire logic overheat_caution, // thermal warning
  input wire logic overheat_shutdown, // thermal shutdown
  input wire logic clip_event, // clipping on any channel
  input wire logic ilimit_event, // current limiting active
  input wire logic [3:0] chan_oc, // channel overcurrent
  input wire logic [3:0] chan_dc, // channel DC detect
  output logic [7:0] chan_state, // effective state per channel
  output logic osc_run, // oscillator enable
  output logic [3:0] cur_limit, // current limit engaged per channel
  output logic warn_pin_o, // warning pin output level
  output logic warn_pin_oe, // warning pin driven low
  output logic fault_pin_o, // error pin output level
  output logic fault_pin_oe // error pin driven low
);
  initial begin
    if (NUM_REGS < 34 || NUM_REGS > 256) $error("NUM_REGS out of range");
  end

  typedef enum {
    S_IDLE, S_ADDR, S_PTR, S_WDATA, S_ACK_SET, S_ACK_HOLD,
    S_RDATA, S_RREL, S_RACK, S_IGNORE
  } ampc_bus_st_t;
  typedef enum logic [1:0] {
    N_PTR, N_WDATA, N_RDATA
  } ampc_after_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [2:0] tgl_s;
    logic [1:0] sel0_s;
    logic [1:0] sel1_s;
    logic scl_prev;
    logic sda_prev;
    ampc_bus_st_t st;
    ampc_after_t after;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic oe;
    logic clr;
    logic [NUM_REGS-1:0][7:0] regs;
  } ampc_port_t;
  ampc_port_t q_reg;
  ampc_port_t q_next;

  logic smp_bit;
  logic smp_tgl;
  logic [7:0] st_rep;
  logic [7:0] chf_rep;
  logic [7:0] glf_rep;
  logic [7:0] wrn_rep;

  ampc_bit_sampler u_sampler (
    .scl_clk(scl_clk),
    .reset_n(reset_n),
    .sda_in(sda_in),
    .bit_val(smp_bit),
    .bit_tgl(smp_tgl)
  );

  ampc_fault_ctrl #(.NUM_CH(4)) u_fault (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .ch_ctrl(q_reg.regs[AMPC_REG_CH_CTRL]),
    .pin_mask(q_reg.regs[AMPC_REG_PIN_CTRL]),
    .fault_clear(q_reg.clr),
    .supply_low_event(supply_low_event),
    .supply_high_event(supply_high_event),
    .overheat_caution(overheat_caution),
    .overheat_shutdown(overheat_shutdown),
    .clip_event(clip_event),
    .ilimit_event(ilimit_event),
    .chan_oc(chan_oc),
    .chan_dc(chan_dc),
    .st_report(st_rep),
    .ch_fault_rep(chf_rep),
    .glb_fault_rep(glf_rep),
    .warn_rep(wrn_rep),
    .osc_run(osc_run),
    .cur_limit(cur_limit),
    .warn_pin_o(warn_pin_o),
    .warn_pin_oe(warn_pin_oe),
    .fault_pin_o(fault_pin_o),
    .fault_pin_oe(fault_pin_oe)
  );

  // Status registers read live state; others read their stored byte.
  function automatic logic [7:0] rd_byte(input ampc_port_t s,
                                         input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == AMPC_REG_CH_STATE) v = st_rep;
    else if (a == AMPC_REG_CH_FAULT) v = chf_rep;
    else if (a == AMPC_REG_GLB_FAULT) v = glf_rep;
    else if (a == AMPC_REG_WARN) v = wrn_rep;
    else if (32'(a) < NUM_REGS) v = s.regs[a];
    return v;
  endfunction : rd_byte

  function automatic logic is_ro(input logic [7:0] a);
    return a == AMPC_REG_CH_STATE || a == AMPC_REG_CH_FAULT
      || a == AMPC_REG_GLB_FAULT || a == AMPC_REG_WARN;
  endfunction : is_ro

  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] byte_in;
    logic [6:0] my_addr;
    rise = q_reg.tgl_s[2] ^ q_reg.tgl_s[1];
    fall = q_reg.scl_prev & ~q_reg.scl_s[1];
    start = q_reg.scl_s[1] & q_reg.scl_prev & q_reg.sda_prev
      & ~q_reg.sda_s[1];
    stop = q_reg.scl_s[1] & q_reg.scl_prev & ~q_reg.sda_prev
      & q_reg.sda_s[1];
    byte_in = {q_reg.sh[6:0], smp_bit};
    my_addr = AMPC_BASE_ADDR
      + {5'h00, q_reg.sel1_s[1], q_reg.sel0_s[1]};
    q_next = q_reg;
    q_next.scl_s = {q_reg.scl_s[0], scl_in};
    q_next.sda_s = {q_reg.sda_s[0], sda_in};
    q_next.tgl_s = {q_reg.tgl_s[1:0], smp_tgl};
    q_next.sel0_s = {q_reg.sel0_s[0], addr_select_low};
    q_next.sel1_s = {q_reg.sel1_s[0], addr_select_high};
    q_next.scl_prev = q_reg.scl_s[1];
    q_next.sda_prev = q_reg.sda_s[1];
    q_next.clr = 1'b0;
    if (start) begin
      // A repeated start keeps the pointer for the read that follows.
      q_next.st = S_ADDR;
      q_next.cnt = 3'h0;
      q_next.oe = 1'b0;
    end else if (stop) begin
      q_next.st = S_IDLE;
      q_next.oe = 1'b0;
    end else begin
      case (q_reg.st)
        S_IDLE, S_IGNORE: begin
          q_next.oe = 1'b0;
        end
        S_ADDR, S_PTR, S_WDATA: begin
          if (rise) begin
            q_next.sh = byte_in;
            q_next.cnt = q_reg.cnt + 3'h1;
            if (q_reg.cnt == 3'h7) begin
              q_next.st = S_ACK_SET;
              if (q_reg.st == S_ADDR) begin
                if (byte_in[7:1] != my_addr) begin
                  q_next.st = S_IGNORE;
                end
                q_next.after = byte_in[0] ? N_RDATA : N_PTR;
              end else if (q_reg.st == S_PTR) begin
                q_next.ptr = byte_in;
                q_next.after = N_WDATA;
              end else begin
                if (32'(q_reg.ptr) < NUM_REGS && !is_ro(q_reg.ptr)) begin
                  q_next.regs[q_reg.ptr] = byte_in;
                end
                if (q_reg.ptr == AMPC_REG_MISC3) begin
                  // The clear bit acts once and always reads back zero.
                  q_next.clr = byte_in[AMPC_CLEAR_BIT];
                  q_next.regs[AMPC_REG_MISC3][AMPC_CLEAR_BIT] = 1'b0;
                end
                q_next.ptr = q_reg.ptr + 8'h01;
                q_next.after = N_WDATA;
              end
            end
          end
        end
        S_ACK_SET: begin
          if (fall) begin
            q_next.oe = 1'b1;
            q_next.st = S_ACK_HOLD;
          end
        end
        S_ACK_HOLD: begin
          // Released on the falling edge that ends the acknowledge clock.
          if (fall) begin
            q_next.oe = 1'b0;
            q_next.cnt = 3'h0;
            case (q_reg.after)
              N_PTR: q_next.st = S_PTR;
              N_WDATA: q_next.st = S_WDATA;
              N_RDATA: begin
                q_next.sh = rd_byte(q_reg, q_reg.ptr);
                q_next.oe = ~q_next.sh[7];
                q_next.ptr = q_reg.ptr + 8'h01;
                q_next.st = S_RDATA;
              end
              default: q_next.st = S_IGNORE;
            endcase
          end
        end
        S_RDATA: begin
          if (rise) begin
            q_next.cnt = q_reg.cnt + 3'h1;
            if (q_reg.cnt == 3'h7) q_next.st = S_RREL;
          end else if (fall) begin
            q_next.sh = {q_reg.sh[6:0], 1'b0};
            q_next.oe = ~q_reg.sh[6];
          end
        end
        S_RREL: begin
          if (fall) begin
            q_next.oe = 1'b0;
            q_next.st = S_RACK;
          end
        end
        S_RACK: begin
          if (rise) begin
            if (!smp_bit) begin
              q_next.after = N_RDATA;
              q_next.st = S_ACK_HOLD;
            end else begin
              q_next.st = S_IGNORE;
            end
          end
        end
        default: q_next.st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q_reg <= '0;
      q_reg.scl_s <= 2'h3;
      q_reg.sda_s <= 2'h3;
      q_reg.scl_prev <= 1'b1;
      q_reg.sda_prev <= 1'b1;
      q_reg.st <= S_IDLE;
      q_reg.after <= N_PTR;
      q_reg.regs[AMPC_REG_CH_CTRL] <= AMPC_CH_CTRL_RST;
      q_reg.regs[AMPC_REG_PIN_CTRL] <= AMPC_PIN_CTRL_RST;
    end else if (ce) begin
      q_reg <= q_next;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = q_reg.oe;
  assign chan_state = st_rep;
endmodule : ampc_ctrl_port

// ### ampc_ctrl_port_chk.sv
// Concurrent checks on the control port pins and channel states.
`timescale 1ns/1ps
module ampc_ctrl_port_chk (
  input wire logic clk, // system clock
  input wire logic reset_n, // synchronous active-low reset
  input wire logic scl_clk, // bus clock
  input wire logic scl_in, // bus clock level
  input wire logic sda_o, // data output level
  input wire logic sda_oe, // data pulled low
  input wire logic supply_low_event, // rail low
  input wire logic supply_high_event, // rail high
  input wire logic overheat_caution, // thermal warning
  input wire logic overheat_shutdown, // thermal shutdown
  input wire logic [3:0] chan_oc, // channel overcurrent
  input wire logic [3:0] chan_dc, // channel DC detect
  input wire logic [7:0] chan_state, // effective states
  input wire logic osc_run, // oscillator enable
  input wire logic warn_pin_o, // warning pin level
  input wire logic warn_pin_oe, // warning pin pulled low
  input wire logic fault_pin_o, // error pin level
  input wire logic fault_pin_oe // error pin pulled low
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Six cycles leave room for the two synchroniser flops and the register.
  wire glb_fault = supply_low_event || supply_high_event || overheat_shutdown;
  AST_SDA_LOW_ONLY: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  AST_PINS_LOW_ONLY: assert property (!warn_pin_o && !fault_pin_o)
    else $error("status pin driven high");
  AST_SDA_MOVES: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed while clock high");
  AST_ACK_HOLD: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("low on data line too short");
  AST_OSC_STOP: assert property (chan_state == 8'hFF [*3] |-> !osc_run)
    else $error("oscillator runs in standby");
  AST_GLB_HIZ: assert property (glb_fault [*6] |-> &(chan_state | 8'hAA))
    else $error("channel active during global fault");
  AST_GLB_PIN: assert property (glb_fault [*6] |-> fault_pin_oe)
    else $error("error pin idle during global fault");
  AST_CH_HIZ: assert property ((chan_oc[1] || chan_dc[1]) [*6] |->
    chan_state[2] && fault_pin_oe)
    else $error("faulty channel not forced off");
  AST_WARN_PIN: assert property (overheat_caution [*6] |-> warn_pin_oe)
    else $error("warning pin idle during thermal warning");
  cover property ($rose(sda_oe));
  cover property ($rose(fault_pin_oe));
  cover property ($fell(warn_pin_oe));
endmodule : ampc_ctrl_port_chk
bind ampc_ctrl_port ampc_ctrl_port_chk ampc_ctrl_port_chk_i (
  .clk, .reset_n, .scl_clk, .scl_in, .sda_o, .sda_oe, .supply_low_event,
  .supply_high_event, .overheat_caution, .overheat_shutdown, .chan_oc,
  .chan_dc, .chan_state, .osc_run, .warn_pin_o, .warn_pin_oe,
  .fault_pin_o, .fault_pin_oe);

// ### ampc_bus_master.sv
// Two-wire bus master model that drives the control port.
`timescale 1ns/1ps
module ampc_bus_master (
  input wire logic lclk, // link timing tick
  input wire logic sda, // resolved data line
  output logic scl_low, // pulls the bus clock low
  output logic sda_low // pulls the data line low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Thirteen ticks keep each clock phase above the 600 ns minimum.
  task automatic half();
    repeat (13) @(posedge lclk);
  endtask : half
  // SDA moves one tick after SCL falls, never in the same time step, so
  // the target cannot see a false start or stop.
  task automatic start();
    @(posedge lclk);
    sda_low = 1'b0;
    repeat (12) @(posedge lclk);
    scl_low = 1'b0;
    half();
    sda_low = 1'b1;
    half();
    scl_low = 1'b1;
  endtask : start
  task automatic stop();
    @(posedge lclk);
    sda_low = 1'b1;
    repeat (12) @(posedge lclk);
    scl_low = 1'b0;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop
  task automatic xbit(input logic b, output logic r);
    @(posedge lclk);
    sda_low = !b;
    repeat (12) @(posedge lclk);
    scl_low = 1'b0;
    half();
    r = sda;
    scl_low = 1'b1;
  endtask : xbit
  // Sending all ones releases the line, so the same task reads a byte.
  task automatic xbyte(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
      q[i] = r;
    end
    xbit(a, k);
  endtask : xbyte
endmodule : ampc_bus_master

// ### ampc_ctrl_port_tb.sv
// Self-checking bench for the amplifier control port.
`timescale 1ns/1ps
module ampc_ctrl_port_tb
  import ampctl_pkg::*;
;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] wdat;
    logic [7:0] rexp;
    logic [7:0] sexp;
  } ampc_row_t;
  localparam ampc_row_t ROWS [5] = '{
    '{8'h04, 8'hE4, 8'hE4, 8'hE4},
    '{8'h04, 8'hFF, 8'hFF, 8'hFF},
    '{8'h04, 8'h00, 8'h00, 8'h00},
    '{8'(AMPC_NUM_REGS), 8'h77, 8'h00, 8'h00},
    '{AMPC_REG_CH_STATE, 8'h3C, 8'h00, 8'h00}};
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic reset_n = 1'b0;
  logic addr_select_low = 1'b0;
  logic addr_select_high = 1'b0;
  logic [2:0] gf = 3'h0;
  logic [2:0] wv = 3'h0;
  logic [3:0] chan_oc = 4'h0;
  logic [3:0] chan_dc = 4'h0;
  logic sda_oe;
  logic warn_pin_oe;
  logic fault_pin_oe;
  logic [7:0] chan_state;
  logic [3:0] cur_limit;
  logic osc_run;
  logic scl_low;
  logic sda_low;
  int errors = 0;
  int checked = 0;
  // Both lines have pull-ups, so a released line reads high.
  wire scl = !scl_low;
  wire sda = !(sda_low || sda_oe);
  initial begin
    forever #5 clk = !clk;
  end
  initial begin
    #7;
    forever #24 lclk = !lclk;
  end
  ampc_ctrl_port ampc_ctrl_port_i (
    .clk, .reset_n, .ce(1'b1), .scl_clk(scl), .scl_in(scl), .sda_in(sda),
    .sda_o(), .sda_oe, .addr_select_low, .addr_select_high,
    .supply_low_event(gf[0]), .supply_high_event(gf[1]),
    .overheat_caution(wv[0]), .overheat_shutdown(gf[2]),
    .clip_event(wv[1]), .ilimit_event(wv[2]), .chan_oc, .chan_dc,
    .chan_state, .osc_run, .cur_limit, .warn_pin_o(), .warn_pin_oe,
    .fault_pin_o(), .fault_pin_oe);
  ampc_bus_master ampc_bus_master_i (.lclk, .sda, .scl_low, .sda_low);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic put(input logic [7:0] b, input logic a);
    logic [7:0] q;
    logic k;
    ampc_bus_master_i.xbyte(b, 1'b1, q, k);
    chk(8'(k), 8'(!a));
  endtask : put
  task automatic get(input logic nk, input logic [7:0] e);
    logic [7:0] q;
    logic k;
    ampc_bus_master_i.xbyte(8'hFF, nk, q, k);
    chk(q, e);
  endtask : get
  task automatic setp(input logic [7:0] p);
    ampc_bus_master_i.start();
    put(8'hD4, 1'b1);
    put(p, 1'b1);
  endtask : setp
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    setp(p);
    put(d, 1'b1);
    ampc_bus_master_i.stop();
    idle(5);
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    setp(p);
    ampc_bus_master_i.start();
    put(8'hD5, 1'b1);
    get(1'b1, e);
    ampc_bus_master_i.stop();
    idle(5);
  endtask : rd
  initial begin
    repeat (10) @(negedge clk);
    chk(chan_state, 8'hFF);
    chk(8'({osc_run, warn_pin_oe, fault_pin_oe, sda_oe}), 8'h04);
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    idle(10);
    chk(chan_state, 8'h00);
    for (int s = 0; s < 4; s++) begin
      {addr_select_high, addr_select_low} = 2'(s);
      idle(10);
      ampc_bus_master_i.start();
      put(8'hD4 + 8'(2 * s), 1'b1);
      ampc_bus_master_i.stop();
      ampc_bus_master_i.start();
      put(8'hD4 + 8'(2 * ((s + 1) % 4)), 1'b0);
      ampc_bus_master_i.stop();
      idle(1);
    end
    {addr_select_high, addr_select_low} = 2'h0;
    idle(10);
    for (int r = 0; r < 5; r++) begin
      wr(ROWS[r].ptr, ROWS[r].wdat);
      rd(ROWS[r].ptr, ROWS[r].rexp);
      chk(chan_state, ROWS[r].sexp);
    end
    setp(8'h05);
    for (int i = 1; i < 5; i++) begin
      put(8'(17 * i), 1'b1);
    end
    ampc_bus_master_i.stop();
    setp(8'h05);
    ampc_bus_master_i.start();
    put(8'hD5, 1'b1);
    for (int i = 1; i < 5; i++) begin
      get(1'(i == 4), 8'(17 * i));
    end
    ampc_bus_master_i.stop();
    idle(5);
    for (int i = 0; i < 3; i++) begin
      gf = 3'(1 << i);
      idle(10);
      chk(chan_state, 8'h55);
      chk(8'(fault_pin_oe), 8'h01);
      gf = 3'h0;
      idle(10);
      chk(chan_state, 8'h00);
      chk(8'(fault_pin_oe), 8'h00);
    end
    wr(AMPC_REG_MISC3, 8'h80);
    chk(8'(warn_pin_oe), 8'h00);
    wv = 3'h7;
    idle(20);
    chk(8'(cur_limit), 8'h0F);
    wv = 3'h0;
    idle(10);
    chk(8'(cur_limit), 8'h00);
    chk(8'(warn_pin_oe), 8'h01);
    chk(chan_state, 8'h00);
    rd(AMPC_REG_WARN, 8'h0E);
    wr(AMPC_REG_MISC3, 8'h80);
    chk(8'(warn_pin_oe), 8'h00);
    chan_oc = 4'h2;
    chan_dc = 4'h4;
    idle(20);
    chan_oc = 4'h0;
    chan_dc = 4'h0;
    idle(10);
    chk(chan_state, 8'h14);
    chk(8'(fault_pin_oe), 8'h01);
    rd(AMPC_REG_CH_FAULT, 8'h24);
    wr(AMPC_REG_MISC3, 8'h80);
    chk(chan_state, 8'h00);
    chk(8'(fault_pin_oe), 8'h00);
    tally_and_finish();
  end
  initial begin
    // A clean run takes about 93,000 cycles.
    repeat (100000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule : ampc_ctrl_port_tb
